//--- src/dcbhi_pkg.sv
// constants shared by both ends of the disk command block host interface
package dcbhi_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int MEM_AW = 32;
   localparam int WORD_W = 16;
   // register numbers (low address digit)
   localparam logic [3:0] REG_PTR_A = 4'h1;
   localparam logic [3:0] REG_PTR_B = 4'h3;
   localparam logic [3:0] REG_PTR_C = 4'h5;
   localparam logic [3:0] REG_PTR_D = 4'h7;
   localparam logic [3:0] REG_VECTOR = 4'h9;
   localparam logic [3:0] REG_UNIT = 4'hB;
   localparam logic [3:0] REG_CONTROL = 4'hD;
   localparam int CTRL_BUSY_BIT = 0;
   localparam int CTRL_IE_BIT = 1;
   // command block word indices
   localparam logic [7:0] W_CMD_STAT = 8'h00;
   localparam logic [7:0] W_EXT_STAT = 8'h01;
   localparam logic [7:0] W_XFER_CNT = 8'h07;
   localparam logic [7:0] W_CYLINDER = 8'h08;
   localparam logic [7:0] W_CUR_CYL = 8'h0A;
   localparam logic [7:0] W_ECC_CALC = 8'h1D;
   localparam logic [7:0] W_ECC_DISK = 8'h20;
   localparam logic [7:0] W_WORK = 8'h25;
   localparam logic [7:0] FETCH_WORDS = 8'h0A;
   localparam logic [7:0] ECC_WORDS = 8'h03;
   localparam logic [7:0] WORK_WORDS = 8'h06;
   localparam logic [7:0] STAT_BUSY = 8'hFF;
   localparam logic [7:0] STAT_OK = 8'h00;
   localparam logic [7:0] CMD_FORMAT = 8'h04;
   localparam logic [7:0] UNIT_ID = 8'h01;
endpackage

//--- src/dcbhi_if.sv
// register port, interrupt and memory master link between host and device
interface dcbhi_if;
   import dcbhi_pkg::*;
   logic reg_sel;
   logic reg_wr;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic reg_ack;
   logic irq;
   logic iack;
   logic [DATA_W-1:0] iack_vector;
   logic mem_req;
   logic mem_wr;
   logic [MEM_AW-1:0] mem_addr;
   logic [WORD_W-1:0] mem_wdata;
   logic [WORD_W-1:0] mem_rdata;
   logic mem_ack;
   modport device (input reg_sel, reg_wr, reg_addr, reg_wdata, iack, mem_rdata, mem_ack,
      output reg_rdata, reg_ack, irq, iack_vector, mem_req, mem_wr, mem_addr, mem_wdata);
   modport host (output reg_sel, reg_wr, reg_addr, reg_wdata, iack, mem_rdata, mem_ack,
      input reg_rdata, reg_ack, irq, iack_vector, mem_req, mem_wr, mem_addr, mem_wdata);
endinterface

//--- src/dcbhi_device.sv
// device end: register file, command fetch and status write-back
// Behaviour
// - odd register numbers one to thirteen only
// - host initialises fully after every reset
// - host loads pointer registers one to seven
// - host programs status/ID register nine
// - host sets handler address for vector
// - host fills command block fields
// - device writes only status/count/current-cylinder/ECC/reserved fields
// - accepted command marks internal status busy
// - host writes busy into memory status
// - format uses cylinder as highest track
// - write computed and disk ECC words
// - six-word working area is device scratch
// - acknowledge returns programmed register nine
// - host polls busy, then sets it
// - unit number in register eleven
// - host checks status, clears busy
module dcbhi_device
   import dcbhi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   dcbhi_if.device bus,
   input wire logic [dcbhi_pkg::WORD_W-1:0] ecc_calc,
   input wire logic [dcbhi_pkg::WORD_W-1:0] ecc_disk,
   output logic busy,
   output logic [7:0] cmd_code,
   output logic [dcbhi_pkg::WORD_W-1:0] max_track
);
   import dcbhi_pkg::*;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_FETCH = 3'b001, S_EXEC = 3'b010, S_WRITE = 3'b011, S_DONE = 3'b100
   } dcbhi_state_t;
   dcbhi_state_t state_q;
   logic [7:0] ptr_q [4];
   logic [7:0] vector_q;
   logic ie_q;
   logic busy_q;
   logic [7:0] status_q;
   logic [7:0] idx_q;
   logic [WORD_W-1:0] cyl_q;
   logic [WORD_W-1:0] wval;
   logic [7:0] widx;
   logic last_w;
   logic wr_ctrl;
   logic irq_q;
   logic unit_q;

   // assembled byte address of a block word
   function automatic logic [MEM_AW-1:0] word_addr(input logic [7:0] w);
      word_addr = {ptr_q[0], ptr_q[1], ptr_q[2], ptr_q[3]} + MEM_AW'({w, 1'b0});
   endfunction

   // decode: only odd numbers respond
   function automatic logic hit(input logic [3:0] a);
      hit = a[0] && (a <= REG_CONTROL);
   endfunction

   assign wr_ctrl = bus.reg_sel && bus.reg_wr && bus.reg_addr == REG_CONTROL;

   // register writes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) ptr_q[i] <= 8'h00;
         vector_q <= 8'h00;
         ie_q <= 1'b0;
      end else if (bus.reg_sel && bus.reg_wr && hit(bus.reg_addr)) begin
         case (bus.reg_addr)
            REG_PTR_A: ptr_q[0] <= bus.reg_wdata;
            REG_PTR_B: ptr_q[1] <= bus.reg_wdata;
            REG_PTR_C: ptr_q[2] <= bus.reg_wdata;
            REG_PTR_D: ptr_q[3] <= bus.reg_wdata;
            REG_VECTOR: vector_q <= bus.reg_wdata;
            REG_CONTROL: ie_q <= bus.reg_wdata[CTRL_IE_BIT];
            default: ;
         endcase
      end
   end

   // register reads
   // read data follows the address of the previous cycle, so it stands together with ack
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus.reg_rdata <= 8'h00;
         bus.reg_ack <= 1'b0;
      end else begin
         bus.reg_ack <= bus.reg_sel && hit(bus.reg_addr) && !bus.reg_ack;
         case (bus.reg_addr)
            REG_PTR_A: bus.reg_rdata <= ptr_q[0];
            REG_PTR_B: bus.reg_rdata <= ptr_q[1];
            REG_PTR_C: bus.reg_rdata <= ptr_q[2];
            REG_PTR_D: bus.reg_rdata <= ptr_q[3];
            REG_VECTOR: bus.reg_rdata <= vector_q;
            REG_UNIT: bus.reg_rdata <= unit_q ? UNIT_ID : 8'h00;
            REG_CONTROL: bus.reg_rdata <= {6'h00, ie_q, busy_q};
            default: bus.reg_rdata <= 8'h00;
         endcase
      end
   end

   // write-back word chosen per step; main status goes last, because in polling mode
   // the host takes its change as the end of the command and may clear busy right after
   always_comb begin
      widx = W_CMD_STAT;
      wval = {cmd_code, status_q};
      last_w = 1'b0;
      if (idx_q == 8'h00) begin
         widx = W_EXT_STAT;
         wval = 16'h0000;
      end else if (idx_q == 8'h01) begin
         widx = W_XFER_CNT;
         wval = 16'h0000;
      end else if (idx_q == 8'h02) begin
         widx = W_CUR_CYL;
         wval = cyl_q;
      end else if (idx_q < 8'h03 + ECC_WORDS) begin
         widx = W_ECC_CALC + idx_q - 8'h03;
         wval = ecc_calc;
      end else if (idx_q < 8'h03 + ECC_WORDS + ECC_WORDS) begin
         widx = W_ECC_DISK + idx_q - 8'h06;
         wval = ecc_disk;
      end else if (idx_q < 8'h09 + WORK_WORDS) begin
         widx = W_WORK + idx_q - 8'h09;
         wval = 16'h0000;
      end else begin
         widx = W_CMD_STAT;
         wval = {cmd_code, status_q};
         last_w = 1'b1;
      end
   end

   // command sequence
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         busy_q <= 1'b0;
         status_q <= STAT_OK;
         idx_q <= 8'h00;
         cmd_code <= 8'h00;
         cyl_q <= 16'h0000;
         max_track <= 16'h0000;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (wr_ctrl) busy_q <= bus.reg_wdata[CTRL_BUSY_BIT];
               // a busy write while already busy starts nothing
               if (wr_ctrl && bus.reg_wdata[CTRL_BUSY_BIT] && !busy_q) begin
                  status_q <= STAT_BUSY;
                  idx_q <= 8'h00;
                  state_q <= S_FETCH;
               end
            end
            S_FETCH: if (bus.mem_ack) begin
               if (idx_q == W_CMD_STAT) cmd_code <= bus.mem_rdata[15:8];
               if (idx_q == W_CYLINDER) cyl_q <= bus.mem_rdata;
               idx_q <= idx_q + 8'h01;
               if (idx_q == FETCH_WORDS - 8'h01) state_q <= S_EXEC;
            end
            S_EXEC: begin
               if (cmd_code == CMD_FORMAT) max_track <= cyl_q;
               status_q <= STAT_OK;
               idx_q <= 8'h00;
               state_q <= S_WRITE;
            end
            S_WRITE: if (bus.mem_ack) begin
               idx_q <= idx_q + 8'h01;
               if (last_w) state_q <= S_DONE;
            end
            S_DONE: begin
               // busy drops only once the whole block is written back
               if (wr_ctrl && !bus.reg_wdata[CTRL_BUSY_BIT]) begin
                  busy_q <= 1'b0;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // interrupt raised once when the write-back ends, dropped by acknowledge;
   // the unit flag outlives the acknowledge so register eleven still names the unit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
         unit_q <= 1'b0;
      end else begin
         if (bus.iack) irq_q <= 1'b0;
         if (wr_ctrl && !bus.reg_wdata[CTRL_BUSY_BIT]) unit_q <= 1'b0;
         // the finishing write-back wins over an acknowledge in the same cycle
         if (state_q == S_WRITE && bus.mem_ack && last_w) begin
            irq_q <= ie_q;
            unit_q <= ie_q;
         end
      end
   end

   // memory master, only the fields the device may change are written
   // word addresses come from the pointer bytes as they stand when the command runs
   assign bus.mem_req = state_q == S_FETCH || state_q == S_WRITE;
   assign bus.mem_wr = state_q == S_WRITE;
   assign bus.mem_addr = word_addr(state_q == S_WRITE ? widx : idx_q);
   assign bus.mem_wdata = wval;
   assign bus.irq = irq_q;
   assign bus.iack_vector = vector_q;
   assign busy = busy_q;
endmodule // dcbhi_device

//--- src/dcbhi_host.sv
// host end: initialise registers, start command, wait and release busy
module dcbhi_host
   import dcbhi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   dcbhi_if.host bus,
   input wire logic start,
   input wire logic [dcbhi_pkg::MEM_AW-1:0] block_addr,
   input wire logic [7:0] vector,
   input wire logic use_irq,
   output logic done,
   output logic error,
   output logic [7:0] unit
);
   import dcbhi_pkg::*;
   typedef enum logic [3:0] {
      H_IDLE = 4'h0, H_INIT = 4'h1, H_POLL = 4'h2, H_MARK = 4'h3, H_GO = 4'h4,
      H_WAIT = 4'h5, H_UNIT = 4'h6, H_STAT = 4'h7, H_CLEAR = 4'h8
   } dcbhi_hstate_t;
   dcbhi_hstate_t st_q;
   logic [2:0] step_q;
   logic [WORD_W-1:0] mem_q [64];
   logic inited_q;
   logic irq_s1, irq_s2;

   // irq passes two flops
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_s1 <= 1'b0;
         irq_s2 <= 1'b0;
      end else begin
         irq_s1 <= bus.irq;
         irq_s2 <= irq_s1;
      end
   end

   // main memory model serving the device master
   always_ff @(posedge clk_sys) begin
      if (bus.mem_req && bus.mem_wr && !bus.mem_ack) mem_q[bus.mem_addr[6:1]] <= bus.mem_wdata;
      if (st_q == H_MARK) mem_q[6'(W_CMD_STAT)] <= {mem_q[6'(W_CMD_STAT)][15:8], STAT_BUSY};
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bus.mem_ack <= 1'b0;
         bus.mem_rdata <= 16'h0000;
      end else begin
         bus.mem_ack <= bus.mem_req && !bus.mem_ack;
         bus.mem_rdata <= mem_q[bus.mem_addr[6:1]];
      end
   end

   assign bus.iack = st_q == H_UNIT && !bus.reg_ack;

   // host sequence
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= H_IDLE;
         step_q <= 3'h0;
         inited_q <= 1'b0;
         bus.reg_sel <= 1'b0;
         bus.reg_wr <= 1'b0;
         bus.reg_addr <= 4'h0;
         bus.reg_wdata <= 8'h00;
         done <= 1'b0;
         error <= 1'b0;
         unit <= 8'h00;
      end else begin
         done <= 1'b0;
         if (bus.reg_ack) bus.reg_sel <= 1'b0;
         case (st_q)
            H_IDLE: if (start) begin
               st_q <= inited_q ? H_POLL : H_INIT;
               step_q <= 3'h0;
            end
            H_INIT: if (!bus.reg_sel) begin
               bus.reg_sel <= 1'b1;
               bus.reg_wr <= 1'b1;
               step_q <= step_q + 3'h1;
               case (step_q)
                  3'h0: begin bus.reg_addr <= REG_PTR_A; bus.reg_wdata <= block_addr[31:24]; end
                  3'h1: begin bus.reg_addr <= REG_PTR_B; bus.reg_wdata <= block_addr[23:16]; end
                  3'h2: begin bus.reg_addr <= REG_PTR_C; bus.reg_wdata <= block_addr[15:8]; end
                  3'h3: begin bus.reg_addr <= REG_PTR_D; bus.reg_wdata <= block_addr[7:0]; end
                  default: begin
                     bus.reg_addr <= REG_VECTOR;
                     bus.reg_wdata <= vector;
                     inited_q <= 1'b1;
                     st_q <= H_POLL;
                  end
               endcase
            end
            H_POLL: if (!bus.reg_sel) begin
               bus.reg_sel <= 1'b1;
               bus.reg_wr <= 1'b0;
               bus.reg_addr <= REG_CONTROL;
            end else if (bus.reg_ack && !bus.reg_wr && !bus.reg_rdata[CTRL_BUSY_BIT]) begin
               st_q <= H_MARK;
            end
            H_MARK: if (!bus.reg_sel) st_q <= H_GO;
            H_GO: begin
               bus.reg_sel <= 1'b1;
               bus.reg_wr <= 1'b1;
               bus.reg_addr <= REG_CONTROL;
               bus.reg_wdata <= {6'h00, use_irq, 1'b1};
               st_q <= H_WAIT;
            end
            H_WAIT: if (!bus.reg_sel && (use_irq ? irq_s2 : mem_q[0][7:0] != STAT_BUSY))
               st_q <= use_irq ? H_UNIT : H_STAT;
            H_UNIT: begin
               bus.reg_sel <= !bus.reg_ack;
               bus.reg_wr <= 1'b0;
               bus.reg_addr <= REG_UNIT;
               if (bus.reg_ack) begin
                  unit <= bus.reg_rdata;
                  st_q <= H_STAT;
               end
            end
            H_STAT: begin
               error <= mem_q[0][7:0] != STAT_OK;
               st_q <= H_CLEAR;
            end
            H_CLEAR: if (!bus.reg_sel) begin
               bus.reg_sel <= 1'b1;
               bus.reg_wr <= 1'b1;
               bus.reg_addr <= REG_CONTROL;
               bus.reg_wdata <= 8'h00;
               done <= 1'b1;
               st_q <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end
endmodule // dcbhi_host

//--- verification/dcbhi_sva.sv
// assertion checker for the host/device link of the disk command block interface
module dcbhi_sva
   import dcbhi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [dcbhi_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dcbhi_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic irq,
   input wire logic iack,
   input wire logic [dcbhi_pkg::DATA_W-1:0] iack_vector,
   input wire logic mem_req,
   input wire logic mem_wr,
   input wire logic [dcbhi_pkg::MEM_AW-1:0] mem_addr,
   input wire logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr_take;
   logic stat_q;
   logic [DATA_W-1:0] vec_q;
   logic [MEM_AW-1:0] ptr_q;
   logic [MEM_AW-1:0] off;
   assign wr_take = reg_ack && reg_sel && reg_wr;
   assign off = mem_addr - ptr_q;
   // shadow of the vector byte and the pointer bytes as the host writes them
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vec_q <= 8'h00;
         ptr_q <= 32'h00000000;
      end else if (wr_take) begin
         if (reg_addr == REG_VECTOR) vec_q <= reg_wdata;
         if (reg_addr == REG_PTR_A) ptr_q[31:24] <= reg_wdata;
         if (reg_addr == REG_PTR_B) ptr_q[23:16] <= reg_wdata;
         if (reg_addr == REG_PTR_C) ptr_q[15:8] <= reg_wdata;
         if (reg_addr == REG_PTR_D) ptr_q[7:0] <= reg_wdata;
      end
   end
   // status word written since the last start
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) stat_q <= 1'b0;
      else if (mem_req && mem_wr && mem_ack && off == 32'h00000000) stat_q <= 1'b1;
      else if (wr_take && reg_addr == REG_CONTROL && reg_wdata[CTRL_BUSY_BIT]) stat_q <= 1'b0;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // link relations
   AST_ACK_ODD: assert property (
      reg_ack |-> $past(reg_sel) && $past(reg_addr[0]) && $past(reg_addr) <= 4'hD)
      else $error("ack for an unmapped register");
   AST_ACK_ONE: assert property (reg_ack |=> !reg_ack)
      else $error("ack longer than one cycle");
   AST_VEC_RET: assert property (iack && !reg_sel |-> iack_vector == vec_q)
      else $error("acknowledge vector differs from programmed byte");
   AST_FETCH_GO: assert property (
      wr_take && reg_addr == REG_CONTROL && reg_wdata[CTRL_BUSY_BIT] |-> ##[0:3] mem_req)
      else $error("no fetch after busy set");
   AST_FETCH_ADR: assert property (
      mem_req && !mem_wr |-> off[0] == 1'b0 && (off >> 1) < FETCH_WORDS)
      else $error("fetch outside command block");
   AST_WR_FIELD: assert property (
      mem_req && mem_wr |-> off[0] == 1'b0 && (off >> 1) inside
      {32'h0, 32'h1, 32'h7, 32'hA, [32'h1D:32'h22], [32'h25:32'h2A]})
      else $error("write to a host-owned field");
   AST_REQ_HOLD: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wr))
      else $error("memory request dropped before ack");
   AST_STAT_FIRST: assert property ($rose(irq) |-> stat_q)
      else $error("interrupt before status write");
   AST_IRQ_HOLD: assert property (irq && !iack |=> irq)
      else $error("interrupt dropped without acknowledge");
endmodule // dcbhi_sva

//--- verification/tb_top.sv
// bench: host and device ends joined, plus a bench-driven second device
module tb_top
   import dcbhi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] PTR2 = 32'h000C0100;
   localparam logic [3:0] RA [5] = '{REG_PTR_A, REG_PTR_B, REG_PTR_C, REG_PTR_D, REG_VECTOR};
   localparam logic [7:0] RV [5] = '{8'h00, 8'h0C, 8'h01, 8'h00, 8'hA7};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic use_irq = 1'b0;
   logic done, error, b1, b2;
   logic [7:0] unit, cmd1, cmd2;
   logic [15:0] trk1, trk2, st0;
   logic [15:0] ecc_c = 16'h5A3C;
   logic [15:0] ecc_d = 16'hC3A5;
   logic [31:0] mw, first_a;
   int rd_cnt = 0;
   int wr_cnt = 0;
   int wbad = 0;
   int err_count = 0;
   int checked = 0;
   dcbhi_if lk();
   dcbhi_if lk2();
   // clock at 10 MHz
   always #50 clk_sys = ~clk_sys;
   // design ends and the checker on the first link
   dcbhi_host dcbhi_host_i (.clk_sys(clk_sys), .rst(rst), .bus(lk.host), .start(start),
      .block_addr(32'h000C2000), .vector(8'h4C), .use_irq(use_irq), .done(done),
      .error(error), .unit(unit));
   dcbhi_device dcbhi_device_i (.clk_sys(clk_sys), .rst(rst), .bus(lk.device),
      .ecc_calc(ecc_c), .ecc_disk(ecc_d), .busy(b1), .cmd_code(cmd1), .max_track(trk1));
   dcbhi_device dcbhi_device_i2 (.clk_sys(clk_sys), .rst(rst), .bus(lk2.device),
      .ecc_calc(ecc_c), .ecc_disk(ecc_d), .busy(b2), .cmd_code(cmd2), .max_track(trk2));
   dcbhi_sva dcbhi_sva_i (.clk_sys(clk_sys), .rst(rst), .reg_sel(lk.reg_sel),
      .reg_wr(lk.reg_wr), .reg_addr(lk.reg_addr), .reg_wdata(lk.reg_wdata),
      .reg_ack(lk.reg_ack), .irq(lk.irq), .iack(lk.iack), .iack_vector(lk.iack_vector),
      .mem_req(lk.mem_req), .mem_wr(lk.mem_wr), .mem_addr(lk.mem_addr), .mem_ack(lk.mem_ack));
   // memory behind the second link: one ack per word, data scrambled when idle
   always @(negedge clk_sys) begin
      mw = (lk2.mem_addr - PTR2) >> 1;
      if (lk2.mem_req === 1'b1 && lk2.mem_ack !== 1'b1) begin
         lk2.mem_ack <= 1'b1;
         if (lk2.mem_wr) begin
            wr_cnt++;
            if (mw == 0) st0 = lk2.mem_wdata;
            if (!(mw inside {0, 1, 7, 10, [29:34], [37:42]})) wbad++;
            if (mw inside {[29:31]} && lk2.mem_wdata !== ecc_c) wbad++;
            if (mw inside {[32:34]} && lk2.mem_wdata !== ecc_d) wbad++;
         end else begin
            if (rd_cnt == 0) first_a = lk2.mem_addr;
            rd_cnt++;
            lk2.mem_rdata <= (mw == 0) ? {CMD_FORMAT, STAT_BUSY} : (mw == 8) ? 16'h0133 : mw[15:0];
         end
      end else begin
         lk2.mem_ack <= 1'b0;
         lk2.mem_rdata <= ~lk2.mem_rdata;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one register access on the second link, bounded wait for ack
   task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d,
      output logic ok, output logic [7:0] q);
      @(negedge clk_sys);
      lk2.reg_sel = 1'b1;
      lk2.reg_wr = wr;
      lk2.reg_addr = a;
      lk2.reg_wdata = d;
      ok = 1'b0;
      q = 8'h00;
      for (int i = 0; i < 5 && !ok; i++) begin
         @(posedge clk_sys);
         ok = (lk2.reg_ack === 1'b1);
         q = lk2.reg_rdata;
      end
      @(negedge clk_sys);
      lk2.reg_sel = 1'b0;
      lk2.reg_wdata = ~d;
   endtask
   task automatic t_regs();
      logic ok;
      logic [7:0] q;
      acc(1'b1, 4'h2, 8'h5A, ok, q);
      chk(ok, 0);
      acc(1'b0, 4'hE, 8'h00, ok, q);
      chk(ok, 0);
      acc(1'b0, 4'hF, 8'h00, ok, q);
      chk(ok, 0);
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, RA[i], RV[i], ok, q);
         acc(1'b0, RA[i], 8'h00, ok, q);
         chk({ok, q}, {1'b1, RV[i]});
      end
      lk2.iack = 1'b1;
      @(negedge clk_sys);
      chk(lk2.iack_vector, 8'hA7);
      lk2.iack = 1'b0;
      acc(1'b0, REG_UNIT, 8'h00, ok, q);
      chk({ok, q}, {1'b1, 8'h00});
   endtask
   task automatic t_format();
      logic ok;
      logic [7:0] q;
      int n;
      acc(1'b1, REG_CONTROL, 8'h03, ok, q);
      chk(b2, 1);
      for (n = 0; n < 300 && lk2.irq !== 1'b1; n++) @(negedge clk_sys);
      chk(lk2.irq, 1);
      chk(st0[7:0], STAT_OK);
      chk(cmd2, CMD_FORMAT);
      chk(trk2, 16'h0133);
      chk(rd_cnt, FETCH_WORDS);
      chk(first_a, PTR2);
      chk(wr_cnt, 16);
      chk(wbad, 0);
      acc(1'b0, REG_UNIT, 8'h00, ok, q);
      chk({ok, q}, {1'b1, UNIT_ID});
      lk2.iack = 1'b1;
      @(negedge clk_sys);
      lk2.iack = 1'b0;
      chk(lk2.irq, 0);
      acc(1'b1, REG_CONTROL, 8'h00, ok, q);
      chk(b2, 0);
   endtask
   // whole command through the host end, interrupt or polling mode
   task automatic t_host(input logic m);
      int n;
      @(negedge clk_sys);
      use_irq = m;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge clk_sys);
      chk(done, 1);
      chk(error, 0);
      if (m) chk(unit, UNIT_ID);
      @(negedge clk_sys);
      chk(b1, 0);
   endtask
   task automatic stop_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      stop_test();
   end
   // main sequence
   initial begin
      lk2.reg_sel = 1'b0;
      lk2.reg_wr = 1'b0;
      lk2.reg_addr = 4'h0;
      lk2.reg_wdata = 8'h00;
      lk2.iack = 1'b0;
      lk2.mem_ack = 1'b0;
      lk2.mem_rdata = 16'h0000;
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      t_regs();
      t_format();
      t_host(1'b1);
      t_host(1'b0);
      rst = 1'b1;
      @(negedge clk_sys);
      rst = 1'b0;
      t_host(1'b1);
      stop_test();
   end
endmodule // tb_top
